// *** inc/flash_ctrl_pkg.sv ***
// Behaviour
// - start accepted only when permitted and unlocked
// - start launches operation, hardware clears when done
// - write permit gates start and detector enable
// - later reset clears only the write permit bit of the control word, plus irq status, mask and read data; cold start clears all
// - sequence fault set on failed operation
// - undervoltage fault set on low supply while permit is set
// - undervoltage live flag follows low-voltage event while permit is set, else reads zero
// - operation select writable only while permit low
// - word and row program; others no-op, reserved
// - page erase and whole-array erase codes
// - protected targets are refused as faults
// - code zero plus start clears fault flags
package flash_ctrl_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam logic [3:0] ADDR_CONTROL = 4'h0;
	localparam logic [3:0] ADDR_KEY = 4'h1;
	localparam logic [3:0] ADDR_TARGET = 4'h2;
	localparam logic [3:0] ADDR_IRQ_STATUS = 4'h3;
	localparam logic [3:0] ADDR_IRQ_MASK = 4'h4;
	localparam int BIT_START = 15;
	localparam int BIT_PERMIT = 14;
	localparam int BIT_SEQ_FAULT = 13;
	localparam int BIT_UV_FAULT = 12;
	localparam int BIT_UV_LIVE = 11;
	localparam int OP_LSB = 0;
	localparam int OP_W = 4;
	localparam logic [31:0] UNLOCK_KEY1 = 32'haa996655;
	localparam logic [31:0] UNLOCK_KEY2 = 32'h556699aa;
	localparam logic [3:0] OP_NONE0 = 4'h0;
	localparam logic [3:0] OP_WORD_PROG = 4'h1;
	localparam logic [3:0] OP_NONE2 = 4'h2;
	localparam logic [3:0] OP_ROW_PROG = 4'h3;
	localparam logic [3:0] OP_PAGE_ERASE = 4'h4;
	localparam logic [3:0] OP_ARRAY_ERASE = 4'h5;
	localparam logic [3:0] OP_NONE6 = 4'h6;
	// interrupt status bits
	localparam int IRQ_DONE = 0;
	localparam int IRQ_FAULT = 1;
	localparam int IRQ_UV = 2;
	localparam int IRQ_W = 3;
	typedef enum logic [1:0] {
		KEY_IDLE,
		KEY_ONE,
		KEY_OPEN
	} key_state_t;
	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_BUSY,
		SEQ_DONE
	} seq_state_t;
endpackage

// *** logic/unlock_tracker.sv ***
`timescale 1ns/1ps
module unlock_tracker
	import flash_ctrl_pkg::*;
(
	input  wire logic              i_clk,
	input  wire logic              i_rst,
	input  wire logic [ADDR_W-1:0] i_addr,
	input  wire logic [DATA_W-1:0] i_wdata,
	input  wire logic              i_wr,
	input  wire logic              i_rd,
	output logic                   o_open
);
	typedef struct packed {
		key_state_t st;
	} key_regs_t;
	key_regs_t r;
	key_regs_t next_r;

	// any access other than the next key breaks the sequence
	always_comb begin
		next_r = r;
		if (i_wr || i_rd) begin
			next_r.st = KEY_IDLE;
			if (i_wr && i_addr == ADDR_KEY && i_wdata == UNLOCK_KEY1) begin
				next_r.st = KEY_ONE;
			end else if (i_wr && i_addr == ADDR_KEY && i_wdata == UNLOCK_KEY2
				&& r.st == KEY_ONE) begin
				next_r.st = KEY_OPEN;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			r <= '{st: KEY_IDLE};
		end else begin
			r <= next_r;
		end
	end

	assign o_open = (r.st == KEY_OPEN);
endmodule

// *** logic/flash_op_runner.sv ***
`timescale 1ns/1ps
module flash_op_runner
	import flash_ctrl_pkg::*;
(
	input  wire logic             i_clk,
	input  wire logic             i_rst,
	input  wire logic             i_launch,
	input  wire logic [OP_W-1:0]  i_op,
	input  wire logic             i_protected,
	input  wire logic             i_any_protected,
	input  wire logic             i_array_done,
	input  wire logic             i_array_fail,
	output logic                  o_array_req,
	output logic [OP_W-1:0]       o_array_op,
	output logic                  o_finish,
	output logic                  o_fail
);
	typedef struct packed {
		seq_state_t     st;
		logic           req;
		logic [OP_W-1:0] op;
		logic           finish;
		logic           fail;
	} run_regs_t;
	run_regs_t r;
	run_regs_t next_r;

	// decode and run one operation to completion
	always_comb begin
		next_r = r;
		next_r.finish = 1'b0;
		case (r.st)
			SEQ_IDLE: begin
				if (i_launch) begin
					next_r.op = i_op;
					next_r.fail = 1'b0;
					if (i_op == OP_WORD_PROG || i_op == OP_ROW_PROG
						|| i_op == OP_PAGE_ERASE) begin
						if (i_protected) begin
							next_r.fail = 1'b1;
							next_r.st = SEQ_DONE;
						end else begin
							next_r.req = 1'b1;
							next_r.st = SEQ_BUSY;
						end
					end else if (i_op == OP_ARRAY_ERASE) begin
						if (i_any_protected) begin
							next_r.fail = 1'b1;
							next_r.st = SEQ_DONE;
						end else begin
							next_r.req = 1'b1;
							next_r.st = SEQ_BUSY;
						end
					end else begin
						next_r.st = SEQ_DONE;
					end
				end
			end
			SEQ_BUSY: begin
				next_r.req = 1'b0;
				if (i_array_done) begin
					next_r.fail = i_array_fail;
					next_r.st = SEQ_DONE;
				end
			end
			default: begin
				next_r.finish = 1'b1;
				next_r.st = SEQ_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			r <= '{st: SEQ_IDLE, req: 1'b0, op: 4'h0, finish: 1'b0, fail: 1'b0};
		end else begin
			r <= next_r;
		end
	end

	assign o_array_req = r.req;
	assign o_array_op = r.op;
	assign o_finish = r.finish;
	assign o_fail = r.fail;
endmodule

// *** logic/flash_program_erase_control.sv ***
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/1ps
module flash_program_erase_control
	import flash_ctrl_pkg::*;
(
	input  wire logic              i_clk,
	input  wire logic              i_rst,
	input  wire logic [ADDR_W-1:0] i_addr,
	input  wire logic [DATA_W-1:0] i_wdata,
	input  wire logic              i_wr,
	input  wire logic              i_rd,
	output logic [DATA_W-1:0]      o_rdata,
	input  wire logic              i_protected,
	input  wire logic              i_any_protected,
	input  wire logic              i_array_done,
	input  wire logic              i_array_fail,
	input  wire logic              i_low_voltage,
	output logic                   o_array_req,
	output logic [OP_W-1:0]        o_array_op,
	output logic [DATA_W-1:0]      o_target_location,
	output logic                   o_detector_enable,
	output logic                   o_irq
);
	typedef struct packed {
		logic              start;
		logic              permit;
		logic              seq_fault;
		logic              uv_fault;
		logic              uv_live;
		logic [OP_W-1:0]   op;
		logic [DATA_W-1:0] target;
		logic [IRQ_W-1:0]  status;
		logic [IRQ_W-1:0]  mask;
		logic [DATA_W-1:0] rdata;
		logic              booted;
	} ctl_regs_t;
	ctl_regs_t r;
	ctl_regs_t next_r;

	logic unlock_open;
	logic launch;
	logic finish;
	logic fail;
	logic ctl_wr;
	logic [IRQ_W-1:0] events;

	unlock_tracker u_unlock (
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_addr  (i_addr),
		.i_wdata (i_wdata),
		.i_wr    (i_wr),
		.i_rd    (i_rd),
		.o_open  (unlock_open)
	);

	flash_op_runner u_runner (
		.i_clk           (i_clk),
		.i_rst           (i_rst),
		.i_launch        (launch),
		.i_op            (r.op),
		.i_protected     (i_protected),
		.i_any_protected (i_any_protected),
		.i_array_done    (i_array_done),
		.i_array_fail    (i_array_fail),
		.o_array_req     (o_array_req),
		.o_array_op      (o_array_op),
		.o_finish        (finish),
		.o_fail          (fail)
	);

	// start accepted only with permit, unlock and idle sequencer
	assign ctl_wr = i_wr && i_addr == ADDR_CONTROL;
	assign launch = ctl_wr && i_wdata[BIT_START] && r.permit && unlock_open
		&& !r.start;

	// register update, flag handling and interrupt status
	always_comb begin
		next_r = r;
		next_r.booted = 1'b1; // cold start finished once reset lets go
		events = '0;
		next_r.rdata = '0;
		if (ctl_wr) begin
			next_r.permit = i_wdata[BIT_PERMIT];
			if (!r.permit) begin
				next_r.op = i_wdata[OP_LSB +: OP_W];
			end
		end
		if (launch) begin
			next_r.start = 1'b1;
		end
		if (i_wr && i_addr == ADDR_TARGET) begin
			next_r.target = i_wdata;
		end
		if (i_wr && i_addr == ADDR_IRQ_MASK) begin
			next_r.mask = i_wdata[IRQ_W-1:0];
		end
		if (i_wr && i_addr == ADDR_IRQ_STATUS) begin
			next_r.status = r.status & ~i_wdata[IRQ_W-1:0];
		end
		// completion clears start and records outcome
		if (finish) begin
			next_r.start = 1'b0;
			events[IRQ_DONE] = 1'b1;
			if (o_array_op == OP_NONE0) begin
				next_r.seq_fault = 1'b0;
				next_r.uv_fault = 1'b0;
			end else if (fail) begin
				next_r.seq_fault = 1'b1;
				events[IRQ_FAULT] = 1'b1;
			end
		end
		// detector runs only while permit is set
		if (r.permit) begin
			next_r.uv_live = i_low_voltage;
			if (i_low_voltage) begin
				next_r.uv_fault = 1'b1;
				events[IRQ_UV] = !r.uv_fault;
			end
		end else begin
			next_r.uv_live = 1'b0;
		end
		// set wins over a simultaneous clear
		next_r.status = next_r.status | events;
		// read data valid the cycle after the strobe
		if (i_rd) begin
			if (i_addr == ADDR_CONTROL) begin
				next_r.rdata[BIT_START] = r.start;
				next_r.rdata[BIT_PERMIT] = r.permit;
				next_r.rdata[BIT_SEQ_FAULT] = r.seq_fault;
				next_r.rdata[BIT_UV_FAULT] = r.uv_fault;
				next_r.rdata[BIT_UV_LIVE] = r.uv_live;
				next_r.rdata[OP_LSB +: OP_W] = r.op;
			end else if (i_addr == ADDR_TARGET) begin
				next_r.rdata = r.target;
			end else if (i_addr == ADDR_IRQ_STATUS) begin
				next_r.rdata[IRQ_W-1:0] = r.status;
			end else if (i_addr == ADDR_IRQ_MASK) begin
				next_r.rdata[IRQ_W-1:0] = r.mask;
			end else begin
				next_r.rdata = '0;
			end
		end
	end

	// cold start clears every field; a later reset drops only permit
	// in the control word, plus bus-side state
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			if (r.booted) begin
				r.permit <= 1'b0;
				r.status <= '0;
				r.mask <= '0;
				r.rdata <= '0;
			end else begin
				r <= '0;
			end
		end else begin
			r <= next_r;
		end
	end

	assign o_rdata = r.rdata;
	assign o_target_location = r.target;
	assign o_detector_enable = r.permit;
	assign o_irq = |(r.status & r.mask);
endmodule

// *** tb/flash_ctrl_chk.sv ***
`timescale 1ns/1ps
module flash_ctrl_chk
	import flash_ctrl_pkg::*;
(
	input wire logic              i_clk,
	input wire logic              i_rst,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [DATA_W-1:0] i_wdata,
	input wire logic              i_wr,
	input wire logic              i_rd,
	input wire logic [DATA_W-1:0] o_rdata,
	input wire logic              i_protected,
	input wire logic              i_any_protected,
	input wire logic              o_array_req,
	input wire logic [OP_W-1:0]   o_array_op,
	input wire logic              o_detector_enable
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	sequence s_ctl_wr; i_wr && i_addr == ADDR_CONTROL; endsequence
	sequence s_quiet; !o_array_req [*3]; endsequence
	logic acc_q1, acc_q2, key_q1, key_q2;
	// recent bus accesses, for the unlock check
	always_ff @(posedge i_clk) begin
		acc_q1 <= i_wr || i_rd;
		acc_q2 <= acc_q1;
		key_q1 <= i_wr && i_addr == ADDR_KEY;
		key_q2 <= key_q1;
	end
	a_permit_to_detector: assert property (s_ctl_wr |=> o_detector_enable == $past(i_wdata[BIT_PERMIT]))
		else $error("detector enable differs from written permit");
	a_reset_drops_permit: assert property (disable iff (1'b0) i_rst |=> !o_detector_enable)
		else $error("permit kept through reset");
	a_req_one_cycle: assert property (o_array_req |=> !o_array_req)
		else $error("array request longer than one cycle");
	a_req_legal_op: assert property (o_array_req |-> o_array_op inside {4'h1, 4'h3, 4'h4, 4'h5})
		else $error("array request for a no-op code");
	a_req_unlocked_target: assert property (o_array_req |->
		!((o_array_op == OP_ARRAY_ERASE) ? i_any_protected : i_protected))
		else $error("array request on protected target");
	a_unkeyed_start: assert property ((s_ctl_wr ##0
		(acc_q1 ? !key_q1 : (acc_q2 && !key_q2))) |=> s_quiet)
		else $error("array request without unlock keys");
	a_rdata_idle_zero: assert property (!i_rd |=> o_rdata == '0)
		else $error("read data outside read answer");
	a_unmapped_zero: assert property (i_rd && i_addr > ADDR_IRQ_MASK |=> o_rdata == '0)
		else $error("unmapped index reads nonzero");
endmodule
bind flash_program_erase_control flash_ctrl_chk flash_ctrl_chk_i (.i_clk(i_clk), .i_rst(i_rst),
	.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
	.i_protected(i_protected), .i_any_protected(i_any_protected), .o_array_req(o_array_req),
	.o_array_op(o_array_op), .o_detector_enable(o_detector_enable));

// *** tb/flash_array_model.sv ***
`timescale 1ns/1ps
module flash_array_model (
	input  wire logic i_clk,
	input  wire logic i_req,
	input  wire logic i_fail,
	input  wire logic i_slow,
	output logic      o_done,
	output logic      o_fail
);
	logic [2:0] count = 3'h0;
	initial o_done = 1'b0;
	initial o_fail = 1'b0;
	// busy countdown; fail line toggles when not beside done
	always @(posedge i_clk) begin
		o_done <= (count == 3'h1);
		o_fail <= (count == 3'h1) ? i_fail : ~o_fail;
		if (i_req)
			count <= i_slow ? 3'h6 : 3'h1;
		else if (count != 3'h0)
			count <= count - 3'h1;
	end
endmodule

// *** tb/flash_program_erase_control_test.sv ***
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin fail_count++; \
	$display("unexpected %s exp %h got %h", n, e, s); end end
module flash_program_erase_control_test
	import flash_ctrl_pkg::*;
;
	logic i_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0, i_protected = 0, i_any_protected = 0;
	logic i_low_voltage = 0, fail_in = 0, slow = 0, fault, array_done, array_fail;
	logic o_array_req, o_detector_enable, o_irq;
	logic [ADDR_W-1:0] i_addr = '0;
	logic [OP_W-1:0] o_array_op;
	logic [DATA_W-1:0] i_wdata = '0, o_rdata, o_target_location, d;
	int fail_count = 0, comparisons = 0, seed = 28309, cyc = 0, reqs = 0, exp_reqs = 0;
	logic [OP_W-1:0] last_op = '0;
	flash_program_erase_control flash_program_erase_control_i (.i_clk(i_clk), .i_rst(i_rst),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_protected(i_protected), .i_any_protected(i_any_protected), .i_array_done(array_done),
		.i_array_fail(array_fail), .i_low_voltage(i_low_voltage), .o_array_req(o_array_req),
		.o_array_op(o_array_op), .o_target_location(o_target_location),
		.o_detector_enable(o_detector_enable), .o_irq(o_irq));
	flash_array_model flash_array_model_i (.i_clk(i_clk), .i_req(o_array_req), .i_fail(fail_in),
		.i_slow(slow), .o_done(array_done), .o_fail(array_fail));
	// clock, request count and hang limit
	always #25 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		cyc++;
		reqs += o_array_req;
		if (o_array_req) last_op = o_array_op;
		if (cyc == 20000) begin
			fail_count++;
			test_done();
		end
	end
	task test_done();
		$display("checks %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge i_clk);
		i_wr <= 1;
		i_addr <= a;
		i_wdata <= v;
		@(posedge i_clk);
		i_wr <= 0;
		#1;
	endtask
	task rd(input logic [3:0] a);
		@(posedge i_clk);
		i_rd <= 1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 0;
		#1 d = o_rdata;
	endtask
	// select, permit, keys, start, then poll until start clears
	task launch(input logic [3:0] op);
		// first write drops permit so the second one stores the code
		wr(ADDR_CONTROL, {28'h0, op});
		wr(ADDR_CONTROL, 32'h4000 | {28'h0, op});
		wr(ADDR_KEY, UNLOCK_KEY1);
		wr(ADDR_KEY, UNLOCK_KEY2);
		wr(ADDR_CONTROL, 32'hc000);
		for (int k = 0; k < 20; k++) begin
			rd(ADDR_CONTROL);
			if (d[BIT_START] === 1'b0) break;
		end
	endtask
	function logic exp_fault(logic f, logic [3:0] op, logic fl, logic p, logic ap);
		case (op)
			OP_NONE0: return 1'b0;
			OP_WORD_PROG, OP_ROW_PROG, OP_PAGE_ERASE: return f | p | fl;
			OP_ARRAY_ERASE: return f | ap | fl;
			default: return f;
		endcase
	endfunction
	// main sequence
	initial begin
		repeat (3) @(posedge i_clk);
		i_rst <= 0;
		rd(ADDR_CONTROL);
		`CHK("ctl reset", 32'h0, d)
		wr(ADDR_IRQ_MASK, 32'h7);
		wr(ADDR_TARGET, 32'h5a5a1234);
		`CHK("target", 32'h5a5a1234, o_target_location)
		rd(4'hf);
		`CHK("unmapped", 32'h0, d)
		fault = 0;
		for (int op = 0; op < 16; op++) begin
			i_protected <= 1'($random(seed));
			i_any_protected <= 1'($random(seed));
			fail_in <= 1'($random(seed));
			slow <= 1'($random(seed));
			launch(4'(op));
			fault = exp_fault(fault, 4'(op), fail_in, i_protected, i_any_protected);
			exp_reqs += (op inside {1, 3, 4, 5}) && !(op == 5 ? i_any_protected : i_protected);
			if ((op inside {1, 3, 4, 5}) && !(op == 5 ? i_any_protected : i_protected))
				`CHK("array op", 4'(op), last_op)
			`CHK("ctl op", {16'h0, 2'b01, fault, 9'h0, 4'(op)}, d)
			`CHK("detector", 1'b1, o_detector_enable)
		end
		`CHK("requests", exp_reqs, reqs)
		`CHK("irq done", 1'b1, o_irq)
		wr(ADDR_IRQ_STATUS, 32'h7);
		`CHK("irq clear", 1'b0, o_irq)
		$display("test ops done");
		wr(ADDR_CONTROL, 32'h4000);
		wr(ADDR_CONTROL, 32'hc005);
		rd(ADDR_CONTROL);
		`CHK("unkeyed", {16'h0, 2'b01, fault, 9'h0, 4'hf}, d)
		i_low_voltage <= 1;
		repeat (3) @(posedge i_clk);
		rd(ADDR_CONTROL);
		`CHK("uv live", 2'b11, d[12:11])
		`CHK("irq uv", 1'b1, o_irq)
		i_low_voltage <= 0;
		repeat (3) @(posedge i_clk);
		rd(ADDR_CONTROL);
		`CHK("uv sticky", 2'b10, d[12:11])
		wr(ADDR_IRQ_MASK, 32'h0);
		`CHK("irq masked", 1'b0, o_irq)
		launch(OP_NONE0);
		`CHK("flags cleared", {16'h0, 2'b01, 14'h0}, d)
		$display("test flags done");
		wr(ADDR_CONTROL, 32'h0);
		wr(ADDR_CONTROL, 32'h3);
		wr(ADDR_CONTROL, 32'h4003);
		@(posedge i_clk);
		i_rst <= 1;
		@(posedge i_clk);
		i_rst <= 0;
		#1 `CHK("detector off", 1'b0, o_detector_enable)
		rd(ADDR_CONTROL);
		`CHK("ctl kept", 32'h3, d)
		$display("test reset done");
		test_done();
	end
endmodule
